//--- rtl/operand_barrel_shifter.sv
/*
  Second-operand generator with status/pc write-back and cycle costs,
  reached over a classic Wishbone slave.
  Assumes software loads the instruction and register values, then
  writes the commit register after the ALU result and flags are in.
*/
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "operand_shift_map.svh"
// What this block does
// - immediate shift amount is a five-bit field, zero to thirty-one
// - left shift zero-fills; lowest bit pushed out becomes carry
// - immediate left shift by zero passes source, carry from status
// - right logical shift zero-fills high bits; last bit out is carry
// - encoded right logical zero means shift by 32: zero, carry bit 31
// - arithmetic right shift fills high bits with the sign bit
// - encoded arithmetic zero means 32: all bits and carry are bit 31
// - rotate right feeds bits out of the low end into the top
// - encoded rotate zero rotates carry-over-source right by one
// - register amount uses only its low byte; never the pc register
// - register amount byte zero passes source and old carry
// - register amounts one to 31 match immediate shifts exactly
// - logical shift by 32 gives zero, edge carry; beyond, zero carry
// - arithmetic shift by register 32 or more gives all sign bits
// - rotate by 32 returns source, carry bit 31; larger wraps by 32
// - register shift with bit 7 set is not data processing
// - immediate is zero-extended byte rotated right by twice field
// - non-pc destination with set-flags updates status from ALU
// - pc destination without set-flags writes pc except for test ops, keeps status
// - pc destination with set-flags restores status, writes pc except for test ops
// - pc as operand reads address plus 8, or 12 for register shift
// - cycle costs: 1S, +1I register shift, 2S+1N when pc written
// - logical ops with set-flags take carry from the shifter
module operand_barrel_shifter (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // datapath outputs
  output logic      [31:0] operand2,
  output logic             shifter_carry,
  output logic      [31:0] program_counter,
  output logic      [31:0] status_word
);
  import operand_shift_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: ack one cycle after the request, dropped after one
  logic        ack_q;
  logic [31:0] rdata_q;
  wire logic   req      = wb_cyc_i && wb_stb_i;
  wire logic   wr_fire  = req && wb_we_i && ack_q;
  wire logic   rd_start = req && !ack_q;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        m[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return m;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////
  // software-loaded registers, then the registered operand and its carry
  logic [31:0] instr_q;
  logic [31:0] src_q;
  logic [31:0] amount_q;
  logic [31:0] addr_q;
  logic [31:0] status_q;
  logic [31:0] saved_q;
  logic [31:0] aluflag_q;
  logic [31:0] result_q;
  logic [31:0] pc_q;
  logic [31:0] op2_q;
  logic        carry_q;

  wire logic w_instr  = wr_fire && (wb_adr_i == `OFS_INSTR);
  wire logic w_src    = wr_fire && (wb_adr_i == `OFS_SRC);
  wire logic w_amount = wr_fire && (wb_adr_i == `OFS_AMOUNT);
  wire logic w_addr   = wr_fire && (wb_adr_i == `OFS_ADDR);
  wire logic w_status = wr_fire && (wb_adr_i == `OFS_STATUS);
  wire logic w_saved  = wr_fire && (wb_adr_i == `OFS_SAVED);
  wire logic w_flag   = wr_fire && (wb_adr_i == `OFS_ALUFLAG);
  wire logic w_result = wr_fire && (wb_adr_i == `OFS_RESULT);
  wire logic w_pc     = wr_fire && (wb_adr_i == `OFS_PC);
  wire logic commit   = wr_fire && (wb_adr_i == `OFS_COMMIT) &&
                        wb_sel_i[0] && wb_dat_i[0];

  ////////////////////////////////////////////////////////////////////////
  // instruction fields
  wire logic        imm_op   = instr_q[`F_IMM];
  wire logic        set_flags_bit = instr_q[`F_SETF];
  wire logic [3:0]  opcode   = instr_q[`F_OPC_HI:`F_OPC_LO];
  wire logic [3:0]  dest     = instr_q[`F_RD_HI:`F_RD_LO];
  wire logic [3:0]  rm_num   = instr_q[`F_RM_HI:`F_RM_LO];
  wire logic        reg_sh   = !imm_op && instr_q[`F_REGSH];
  wire shift_kind_t kind     =
    shift_kind_t'(instr_q[`F_TYPE_HI:`F_TYPE_LO]);
  wire logic [4:0]  imm_amt  = instr_q[`F_AMT_HI:`F_AMT_LO];
  wire logic [7:0]  reg_amt  = amount_q[7:0];
  wire logic [7:0]  sh_amt   = reg_sh ? reg_amt : {3'h0, imm_amt};
  wire logic [3:0]  rot_fld  = instr_q[`F_ROT_HI:`F_ROT_LO];
  wire logic [7:0]  imm8     = instr_q[`F_IMM8_HI:0];
  wire logic        c_flag   = status_q[`F_C];
  // a register shift with bit 7 set decodes as multiply or undefined
  wire logic        undef    = reg_sh && instr_q[`F_REGSH_B7];
  wire logic        logical  = (opcode[2:1] == 2'b00) ||
                               (opcode[3:2] == 2'b11);
  wire logic        test_op  = (opcode[3:2] == 2'b10);
  wire logic        dest_pc  = (dest == `PC_REG);
  wire logic        pc_write = dest_pc && !test_op;

  ////////////////////////////////////////////////////////////////////////
  // operand path
  // prefetch makes the pc read further ahead when a register shifts
  wire logic [31:0] pc_view  = addr_q + (reg_sh ? `PC_AHEAD_REG
                                                : `PC_AHEAD_IMM);
  wire logic [31:0] src_val  = (rm_num == `PC_REG) ? pc_view : src_q;
  wire logic [31:0] imm_ext  = {24'h000000, imm8};
  wire logic [63:0] imm_dbl  = {imm_ext, imm_ext} >> {rot_fld, 1'b0};
  wire logic [31:0] imm_rot  = imm_dbl[31:0];
  wire logic        imm_c    = (rot_fld == 4'h0) ? c_flag : imm_rot[31];
  wire logic [31:0] sh_res;
  wire logic        sh_c;

  barrel_shift_core u_core (
    .value    (src_val),
    .kind     (kind),
    .amount   (sh_amt),
    .by_reg   (reg_sh),
    .carry_in (c_flag),
    .result   (sh_res),
    .carry    (sh_c)
  );

  wire logic [31:0] op2_d   = imm_op ? imm_rot : sh_res;
  wire logic        carry_d = imm_op ? imm_c : sh_c;

  ////////////////////////////////////////////////////////////////////////
  // write-back of status word and pc on commit
  wire logic [31:0] flags_in = aluflag_q;
  wire logic [31:0] upd_logic = {flags_in[`F_N], flags_in[`F_Z], carry_q,
                                 status_q[`F_V:0]};
  wire logic [31:0] upd_arith = {flags_in[`F_N:`F_V], status_q[27:0]};
  wire logic        do_flags = commit && !undef && set_flags_bit &&
                               !dest_pc;
  wire logic        do_restore = commit && !undef && set_flags_bit &&
                                 dest_pc;
  wire logic        do_pc    = commit && !undef && pc_write;
  wire logic [31:0] status_d =
    do_restore ? saved_q :
    do_flags   ? (logical ? upd_logic : upd_arith) :
    w_status   ? merge(status_q, wb_dat_i, wb_sel_i) : status_q;
  wire logic [31:0] pc_d     =
    do_pc ? result_q :
    w_pc  ? merge(pc_q, wb_dat_i, wb_sel_i) : pc_q;

  ////////////////////////////////////////////////////////////////////////
  // cycle cost of the loaded instruction
  wire logic [1:0]  s_cyc = pc_write ? 2'h2 : 2'h1;
  wire logic [1:0]  n_cyc = pc_write ? 2'h1 : 2'h0;
  wire logic [1:0]  i_cyc = reg_sh ? 2'h1 : 2'h0;

  wire logic [31:0] info_w = (32'h1 << `I_CARRY) & {32{carry_q}} |
                             (32'h1 << `I_UNDEF) & {32{undef}} |
                             {30'h0, s_cyc} << `I_S_LO |
                             {30'h0, n_cyc} << `I_N_LO |
                             {30'h0, i_cyc} << `I_I_LO;

  ////////////////////////////////////////////////////////////////////////
  // read decode; unmapped offsets answer zero
  wire logic [31:0] rd_mux =
    (wb_adr_i == `OFS_INSTR)   ? instr_q   :
    (wb_adr_i == `OFS_SRC)     ? src_q     :
    (wb_adr_i == `OFS_AMOUNT)  ? amount_q  :
    (wb_adr_i == `OFS_ADDR)    ? addr_q    :
    (wb_adr_i == `OFS_STATUS)  ? status_q  :
    (wb_adr_i == `OFS_SAVED)   ? saved_q   :
    (wb_adr_i == `OFS_ALUFLAG) ? aluflag_q :
    (wb_adr_i == `OFS_RESULT)  ? result_q  :
    (wb_adr_i == `OFS_OPERAND) ? op2_q     :
    (wb_adr_i == `OFS_INFO)    ? info_w    :
    (wb_adr_i == `OFS_PC)      ? pc_q      : `RESET_WORD;

  ////////////////////////////////////////////////////////////////////////
  // flip-flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q   <= 1'b0;
      rdata_q <= `RESET_WORD;
    end else begin
      ack_q   <= rd_start;
      rdata_q <= rd_start ? rd_mux : rdata_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      instr_q   <= `RESET_WORD;
      src_q     <= `RESET_WORD;
      amount_q  <= `RESET_WORD;
      addr_q    <= `RESET_WORD;
      saved_q   <= `RESET_WORD;
      aluflag_q <= `RESET_WORD;
      result_q  <= `RESET_WORD;
    end else begin
      if (w_instr)  instr_q   <= merge(instr_q, wb_dat_i, wb_sel_i);
      if (w_src)    src_q     <= merge(src_q, wb_dat_i, wb_sel_i);
      if (w_amount) amount_q  <= merge(amount_q, wb_dat_i, wb_sel_i);
      if (w_addr)   addr_q    <= merge(addr_q, wb_dat_i, wb_sel_i);
      if (w_saved)  saved_q   <= merge(saved_q, wb_dat_i, wb_sel_i);
      if (w_flag)   aluflag_q <= merge(aluflag_q, wb_dat_i, wb_sel_i);
      if (w_result) result_q  <= merge(result_q, wb_dat_i, wb_sel_i);
    end
  end

  // the operand follows its inputs with one cycle of latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op2_q    <= `RESET_WORD;
      carry_q  <= 1'b0;
      status_q <= `RESET_WORD;
      pc_q     <= `RESET_WORD;
    end else begin
      op2_q    <= op2_d;
      carry_q  <= carry_d;
      status_q <= status_d;
      pc_q     <= pc_d;
    end
  end

  assign operand2        = op2_q;
  assign shifter_carry   = carry_q;
  assign program_counter = pc_q;
  assign status_word     = status_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  wire logic imm_sh = !imm_op && !reg_sh;
  wire logic quiet  = !wr_fire;

  sequence lsl0_s;
    quiet && imm_sh && kind == shift_left_logical && imm_amt == 5'h00;
  endsequence
  sequence pc_commit_s;
    commit && !undef && dest_pc;
  endsequence

  lsl_zero_pass_a: assert property (
    lsl0_s |=> op2_q == $past(src_val) && carry_q == $past(c_flag))
    else $error("left shift by zero changed source or carry");

  lsr_thirtytwo_a: assert property (
    quiet && imm_sh && kind == shift_right_logical && imm_amt == 5'h00
    |=> op2_q == 32'h0 && carry_q == $past(src_val[31]))
    else $error("encoded right shift zero is not shift by 32");

  asr_thirtytwo_a: assert property (
    quiet && imm_sh && kind == shift_right_arith && imm_amt == 5'h00
    |=> op2_q == {32{$past(src_val[31])}} &&
        carry_q == $past(src_val[31]))
    else $error("encoded arithmetic zero is not sign fill");

  rotate_extend_a: assert property (
    quiet && imm_sh && kind == rotate_right && imm_amt == 5'h00
    |=> op2_q == {$past(c_flag), $past(src_val[31:1])} &&
        carry_q == $past(src_val[0]))
    else $error("rotate-extended result wrong");

  reg_zero_pass_a: assert property (
    quiet && reg_sh && reg_amt == 8'h00
    |=> op2_q == $past(src_val) && carry_q == $past(c_flag))
    else $error("register zero amount changed operand");

  big_logic_zero_a: assert property (
    quiet && reg_sh && kind != shift_right_arith &&
    kind != rotate_right && reg_amt > `SHIFT_32
    |=> op2_q == 32'h0 && !carry_q)
    else $error("logical shift beyond 32 not zero");

  imm_rotate_a: assert property (
    quiet && imm_op && rot_fld == 4'h1
    |=> op2_q == {$past(imm8[1:0]), 24'h0, $past(imm8[7:2])})
    else $error("immediate rotate by two wrong");

  pc_keep_status_a: assert property (
    pc_commit_s ##0 !set_flags_bit ##0 !test_op
    |=> status_q == $past(status_q) && pc_q == $past(result_q))
    else $error("pc write without set-flags touched status");

  restore_status_a: assert property (
    pc_commit_s ##0 set_flags_bit |=> status_q == $past(saved_q))
    else $error("saved status not restored on pc write");

  pc_offset_a: assert property (
    quiet && imm_sh && rm_num == `PC_REG &&
    kind == shift_left_logical && imm_amt == 5'h00
    |=> op2_q == $past(addr_q) + `PC_AHEAD_IMM)
    else $error("pc operand offset wrong");

  undef_blocked_a: assert property (
    commit && undef |=> status_q == $past(status_q) &&
                        pc_q == $past(pc_q))
    else $error("undefined encoding wrote back");

  logic_carry_a: assert property (
    commit && !undef && set_flags_bit && !dest_pc && logical
    |=> status_q[`F_C] == $past(carry_q) &&
        status_q[`F_V] == $past(status_q[`F_V]))
    else $error("logical op carry not from shifter");
endmodule : operand_barrel_shifter
`default_nettype wire

//--- rtl/operand_shift_map.svh
/*
  Offsets, field positions and fixed figures of the operand shifter.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef OPERAND_SHIFT_MAP_SVH
`define OPERAND_SHIFT_MAP_SVH
// register byte offsets on the bus
`define OFS_INSTR    8'h00
`define OFS_SRC      8'h04
`define OFS_AMOUNT   8'h08
`define OFS_ADDR     8'h0c
`define OFS_STATUS   8'h10
`define OFS_SAVED    8'h14
`define OFS_ALUFLAG  8'h18
`define OFS_RESULT   8'h1c
`define OFS_OPERAND  8'h20
`define OFS_INFO     8'h24
`define OFS_COMMIT   8'h28
`define OFS_PC       8'h2c
// instruction word fields
`define F_IMM        25
`define F_OPC_HI     24
`define F_OPC_LO     21
`define F_SETF       20
`define F_RD_HI      15
`define F_RD_LO      12
`define F_RS_HI      11
`define F_RS_LO      8
`define F_ROT_HI     11
`define F_ROT_LO     8
`define F_AMT_HI     11
`define F_AMT_LO     7
`define F_REGSH_B7   7
`define F_TYPE_HI    6
`define F_TYPE_LO    5
`define F_REGSH      4
`define F_RM_HI      3
`define F_RM_LO      0
`define F_IMM8_HI    7
// status word flag positions
`define F_N          31
`define F_Z          30
`define F_C          29
`define F_V          28
// info register layout
`define I_CARRY      0
`define I_UNDEF      1
`define I_S_LO       8
`define I_N_LO       12
`define I_I_LO       16
// fixed figures
`define PC_REG       4'hf
`define PC_AHEAD_IMM 32'h0000_0008
`define PC_AHEAD_REG 32'h0000_000c
`define RESET_WORD   32'h0000_0000
`define SHIFT_32     8'h20
`endif

//--- rtl/operand_shift_pkg.sv
/*
  Types shared by the operand generator and its shift core.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package operand_shift_pkg;
  typedef enum logic [1:0] {
    shift_left_logical = 2'b00,
    shift_right_logical = 2'b01,
    shift_right_arith = 2'b10,
    rotate_right = 2'b11
  } shift_kind_t;
endpackage : operand_shift_pkg

//--- rtl/barrel_shift_core.sv
/*
  Combinational barrel shifter with carry out and zero-amount encodings.
  Assumes operands stable for the cycle; output is sampled by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "operand_shift_map.svh"
module barrel_shift_core (
  // operand and control
  input  wire logic                        [31:0] value,
  input  wire operand_shift_pkg::shift_kind_t     kind,
  input  wire logic                        [7:0]  amount,
  input  wire logic                               by_reg,
  input  wire logic                               carry_in,
  // result
  output logic                             [31:0] result,
  output logic                                    carry
);
  import operand_shift_pkg::*;

  // an encoded zero means 32 for right shifts, rotate-extended for ror
  wire logic        imm_zero = !by_reg && (amount == 8'h00);
  wire logic        is_rrx   = imm_zero && (kind == rotate_right);
  wire logic [7:0]  eff_amt  = (imm_zero && kind != shift_left_logical &&
                                kind != rotate_right) ? `SHIFT_32
                                : amount;
  // 33-bit forms keep the last bit out in the extra position
  wire logic [32:0] lsl_w = {1'b0, value} << eff_amt;
  wire logic [32:0] lsr_w = {value, 1'b0} >> eff_amt;
  wire logic [32:0] asr_w =
    33'($signed({value, 1'b0}) >>> eff_amt);
  wire logic [63:0] ror_w = {value, value} >> eff_amt[4:0];

  always_comb begin
    result = value;
    carry  = carry_in;
    if (is_rrx) begin
      result = {carry_in, value[31:1]};
      carry  = value[0];
    end else if (eff_amt == 8'h00) begin
      result = value;
      carry  = carry_in;
    end else begin
      case (kind)
        shift_left_logical: begin
          result = lsl_w[31:0];
          carry  = lsl_w[32];
        end
        shift_right_logical: begin
          result = lsr_w[32:1];
          carry  = lsr_w[0];
        end
        shift_right_arith: begin
          result = asr_w[32:1];
          carry  = asr_w[0];
        end
        rotate_right: begin
          result = ror_w[31:0];
          carry  = ror_w[31];
        end
        default: begin
          result = value;
          carry  = carry_in;
        end
      endcase
    end
  end
endmodule : barrel_shift_core
`default_nettype wire

//--- verif/alu_model.sv
/*
  Stand-in for the core's ALU at the far side of the operand outputs.
  Assumes a move-class operation, so the result is operand2 itself.
*/
`timescale 1ns/1ps
`default_nettype none
module alu_model (
  // operand from the shifter
  input  wire logic [31:0] operand2,
  input  wire logic        shifter_carry,
  // result and flags, nzcv in bits 31:28
  output logic      [31:0] alu_result,
  output logic      [31:0] alu_flags
);
  // v is left clear so that a kept v flag can be told apart
  assign alu_result = operand2;
  assign alu_flags  = {operand2[31], operand2 == 32'h0, shifter_carry,
                       1'b0, 28'h0};
endmodule : alu_model
`default_nettype wire

//--- verif/operand_barrel_shifter_tb.sv
/*
  Self-checking bench for the operand shifter over its wishbone port.
  Assumes the bus slave answers with ack and the alu model beside it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "operand_shift_map.svh"
module operand_barrel_shifter_tb;
  import operand_shift_pkg::*;
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, op2, pc, stat, alu_res, alu_flg;
  logic        ack, scarry;
  int          miscompares = 0;
  int          compares = 0;
  always #50 clk = ~clk;
  operand_barrel_shifter u_dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .operand2(op2),
    .shifter_carry(scarry), .program_counter(pc), .status_word(stat));
  alu_model u_alu (.operand2(op2), .shifter_carry(scarry),
    .alu_result(alu_res), .alu_flags(alu_flg));
  //////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      miscompares++;
      final_report();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  //////////////////////////////////////////////////////////////////////
  // expected {carry, operand} worked out from the shift definitions
  function automatic logic [32:0] ref_op(input logic [1:0] k,
      input logic [7:0] a, input logic byreg, input logic [31:0] v,
      input logic c);
    logic [63:0] w;
    if (a == 8'h00)
      ref_op = (byreg || k == 2'b00) ? {c, v} : k == 2'b01 ?
               {v[31], 32'h0} : k == 2'b10 ? {33{v[31]}} : {v[0], c, v[31:1]};
    else if (k == 2'b00) begin
      w = {32'h0, v} << a;
      ref_op = w[32:0];
    end else if (k == 2'b01) begin
      w = {v, 32'h0} >> a;
      ref_op = {w[31], w[63:32]};
    end else if (k == 2'b10) begin
      w = $signed({v, 32'h0}) >>> a;
      ref_op = {w[31], w[63:32]};
    end else begin
      w = {v, v} >> a[4:0];
      ref_op = {w[31], w[31:0]};
    end
  endfunction : ref_op
  function automatic logic [31:0] ins(input logic [3:0] opc, rd,
      input logic s, input logic [4:0] f, input logic [1:0] k,
      input logic rs);
    return {7'h00, opc, s, 4'h0, rd, f, k, rs, 4'h0};
  endfunction : ins
  // cyc_e packs the expected i, n and s cycle counts, two bits each
  task automatic do_op(input logic [31:0] iw, src, amt, input logic cin,
                       input logic [32:0] exp, input logic [5:0] cyc_e);
    logic [31:0] q;
    wr(`OFS_STATUS, {2'b00, cin, 29'h0});
    wr(`OFS_SRC, src);
    wr(`OFS_AMOUNT, amt);
    wr(`OFS_INSTR, iw);
    repeat (2) @(posedge clk);
    rd(`OFS_OPERAND, q);
    check("operand", q, exp[31:0]);
    check("operand2", op2, exp[31:0]);
    check("shifter_carry", {31'h0, scarry}, {31'h0, exp[32]});
    rd(`OFS_INFO, q);
    check("info carry", {31'h0, q[0]}, {31'h0, exp[32]});
    check("cycles", {26'h0, q[17:16], q[13:12], q[9:8]},
          {26'h0, cyc_e});
  endtask : do_op
  task automatic commit;
    wr(`OFS_ALUFLAG, alu_flg);
    wr(`OFS_RESULT, alu_res);
    wr(`OFS_COMMIT, 32'h1);
    repeat (2) @(posedge clk);
  endtask : commit
  //////////////////////////////////////////////////////////////////////
  task automatic t_imm_shifts;
    logic [4:0] a;
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 4; j++) begin
        a = j == 0 ? 5'd0 : j == 1 ? 5'd1 : j == 2 ? 5'd5 : 5'd31;
        do_op(ins(4'hd, 4'h2, 1'b0, a, k[1:0], 1'b0), 32'hc000_0035,
              32'h0, ~j[0], ref_op(k[1:0], {3'h0, a}, 1'b0,
              32'hc000_0035, ~j[0]), 6'h01);
      end
  endtask : t_imm_shifts
  task automatic t_reg_shifts;
    logic [7:0] a;
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 6; j++) begin
        a = j == 0 ? 8'd0 : j == 1 ? 8'd1 : j == 2 ? 8'd31 :
            j == 3 ? 8'd32 : j == 4 ? 8'd33 : 8'd100;
        // amount register number 1, never the pc
        do_op(ins(4'hd, 4'h2, 1'b0, 5'h02, k[1:0], 1'b1), 32'hc000_0035,
              {24'hffffff, a}, 1'b1, ref_op(k[1:0], a, 1'b1,
              32'hc000_0035, 1'b1), 6'h11);
      end
  endtask : t_reg_shifts
  task automatic t_imm_rotate;
    logic [3:0] r;
    for (int j = 0; j < 4; j++) begin
      r = j == 0 ? 4'd0 : j == 1 ? 4'd1 : j == 2 ? 4'd4 : 4'd15;
      do_op({7'h01, 4'hd, 1'b0, 4'h0, 4'h2, r, 8'hf3}, 32'h0, 32'h0,
            1'b1, ref_op(2'b11, {3'h0, r, 1'b0}, 1'b1, 32'h0000_00f3,
            1'b1), 6'h01);
    end
  endtask : t_imm_rotate
  task automatic t_pc_operand;
    wr(`OFS_ADDR, 32'h0000_0100);
    do_op(ins(4'hd, 4'h2, 1'b0, 5'h00, 2'b00, 1'b0) | 32'hf, 32'h0, 32'h0,
          1'b0, {1'b0, 32'h0000_0108}, 6'h01);
    do_op(ins(4'hd, 4'h2, 1'b0, 5'h02, 2'b00, 1'b1) | 32'hf, 32'h0, 32'h0,
          1'b0, {1'b0, 32'h0000_010c}, 6'h11);
  endtask : t_pc_operand
  task automatic t_commit;
    logic [31:0] q;
    do_op(ins(4'hd, 4'h2, 1'b1, 5'h02, 2'b00, 1'b1), 32'h8000_0001,
          32'h1, 1'b0, {1'b1, 32'h2}, 6'h11);
    wr(`OFS_STATUS, 32'h1000_0000);
    commit();
    check("status flags", stat, 32'h3000_0000);
    check("pc kept", pc, 32'h0);
    do_op({7'h01, 4'hd, 1'b0, 4'h0, 4'hf, 4'h0, 8'h40}, 32'h0, 32'h0,
          1'b0, {1'b0, 32'h40}, 6'h06);
    wr(`OFS_STATUS, 32'h5000_0000);
    commit();
    check("pc written", pc, 32'h40);
    check("status kept", stat, 32'h5000_0000);
    wr(`OFS_SAVED, 32'ha000_0000);
    do_op(ins(4'hd, 4'hf, 1'b1, 5'h02, 2'b00, 1'b1), 32'h20, 32'h2,
          1'b0, {1'b0, 32'h80}, 6'h16);
    commit();
    check("status restored", stat, 32'ha000_0000);
    check("pc restored", pc, 32'h80);
    // bit 7 set turns this into a non data processing encoding
    wr(`OFS_STATUS, 32'h0);
    wr(`OFS_INSTR, ins(4'hd, 4'h3, 1'b1, 5'h03, 2'b00, 1'b1));
    wr(`OFS_ALUFLAG, 32'hf000_0000);
    wr(`OFS_COMMIT, 32'h1);
    repeat (2) @(posedge clk);
    check("status untouched", stat, 32'h0);
    rd(`OFS_INFO, q);
    check("undefined", {31'h0, q[1]}, 32'h1);
    rd(8'h40, q);
    check("unmapped", q, 32'h0);
  endtask : t_commit
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_imm_shifts();
    t_reg_shifts();
    t_imm_rotate();
    t_pc_operand();
    t_commit();
    final_report();
  end
endmodule : operand_barrel_shifter_tb
`default_nettype wire
